// file: dv/pmr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmr_host_model
  import pmr_pkg::*;
(
  input wire logic clock, // system clock
  output logic cmd_valid, // command strobe
  output logic cmd_write, // write select
  output logic [7:0] cmd_code, // command code
  output logic [15:0] cmd_wdata, // write data
  input wire logic [63:0] rd_data, // read answer
  input wire logic rd_valid, // read answer strobe
  input wire logic cmd_error // refusal strobe
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // one command, answer taken one cycle after it stands
  task automatic issue(input logic w, input logic [7:0] code, input logic [15:0] wd,
    output logic [63:0] data, output logic vld, output logic err);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(posedge clock);
    cmd_valid <= 1'b0;
    // idle lines carry garbage, not the last value
    cmd_code <= ~code;
    cmd_wdata <= ~wd;
    #1;
    data = rd_data;
    vld = rd_valid;
    err = cmd_error;
  endtask
endmodule // pmr_host_model
`default_nettype wire

// file: dv/pmr_readout_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define check_eq(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
  end
module pmr_readout_regs_bench
  import pmr_pkg::*;
;
  logic clock;
  logic reset_n;
  logic cmd_valid;
  logic cmd_write;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata;
  logic [63:0] rd_data;
  logic rd_valid;
  logic cmd_error;
  logic power_valid;
  logic [15:0] power_sample;
  logic aux_valid;
  logic [11:0] aux_sample;
  logic current_valid;
  logic [15:0] current_sample;
  logic aux_ov_warn;
  logic aux_uv_warn;
  logic alert1;
  logic alert2;
  logic [63:0] rd_data_sgn;
  int bad_count = 0;
  int checks = 0;
  int cycle_count = 0;

  pmr_readout_regs #(.SIGNED_ENERGY(1'b0)) i_pmr_readout_regs (.clock(clock),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_error(cmd_error),
    .power_valid(power_valid), .power_sample(power_sample), .aux_valid(aux_valid),
    .aux_sample(aux_sample), .current_valid(current_valid), .current_sample(current_sample),
    .aux_ov_warn(aux_ov_warn), .aux_uv_warn(aux_uv_warn), .alert1(alert1), .alert2(alert2));
  // signed energy variant on the same stimulus, only its record is compared
  pmr_readout_regs #(.SIGNED_ENERGY(1'b1)) i_pmr_readout_regs_sgn (.clock(clock),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data_sgn), .rd_valid(), .cmd_error(),
    .power_valid(power_valid), .power_sample(power_sample), .aux_valid(aux_valid),
    .aux_sample(aux_sample), .current_valid(current_valid), .current_sample(current_sample),
    .aux_ov_warn(), .aux_uv_warn(), .alert1(), .alert2());
  pmr_host_model i_pmr_host_model (.clock(clock), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_error(cmd_error));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard, tests need about 630 cycles
  always @(posedge clock)
  begin
    cycle_count++;
    if (cycle_count == 5000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic rd(input logic [7:0] code, input logic [63:0] exp);
    logic [63:0] d;
    logic v;
    logic e;
    i_pmr_host_model.issue(1'b0, code, 16'h0000, d, v, e);
    `check_eq("read strobe", 1'b1, v)
    `check_eq("read refusal", 1'b0, e)
    `check_eq("read data", exp, d)
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] wd, input logic exp_err);
    logic [63:0] d;
    logic v;
    logic e;
    i_pmr_host_model.issue(1'b1, code, wd, d, v, e);
    `check_eq("write refusal", exp_err, e)
  endtask

  task automatic send_power(input logic [15:0] s);
    @(posedge clock);
    power_valid <= 1'b1;
    power_sample <= s;
    @(posedge clock);
    power_valid <= 1'b0;
    power_sample <= ~s;
  endtask

  task automatic send_current(input logic [15:0] s);
    @(posedge clock);
    current_valid <= 1'b1;
    current_sample <= s;
    @(posedge clock);
    current_valid <= 1'b0;
    current_sample <= ~s;
  endtask

  // aux sample, then warnings (one-cycle lag) and alerts (two-cycle lag) checked together
  task automatic aux_case(input logic [11:0] s, input logic [3:0] exp);
    @(posedge clock);
    aux_valid <= 1'b1;
    aux_sample <= s;
    @(posedge clock);
    aux_valid <= 1'b0;
    aux_sample <= ~s;
    repeat (2) @(posedge clock);
    #1;
    `check_eq("ov uv alert1 alert2", exp, {aux_ov_warn, aux_uv_warn, alert1, alert2})
  endtask

  task automatic test_reset();
    logic [63:0] d;
    logic v;
    logic e;
    rd(PMR_CMD_ENERGY_REC, 64'h0);
    rd(PMR_CMD_AUX_READ, 64'h0);
    rd(PMR_CMD_AUX_OV_LIMIT, 64'h0FFF);
    rd(PMR_CMD_AUX_UV_LIMIT, 64'h0);
    rd(PMR_CMD_MIN_CURRENT, 64'h07FF);
    rd(PMR_CMD_MIN_POWER, 64'h7FFF);
    rd(PMR_CMD_ALERT1_CFG, 64'h0);
    rd(PMR_CMD_ALERT2_CFG, 64'h0);
    i_pmr_host_model.issue(1'b0, 8'h00, 16'h0000, d, v, e);
    `check_eq("unknown code", 1'b1, e)
    `check_eq("unknown code data", 64'h0, d)
    wr(PMR_CMD_ENERGY_REC, 16'h1234, 1'b1);
    wr(PMR_CMD_AUX_READ, 16'h1234, 1'b1);
    rd(PMR_CMD_AUX_READ, 64'h0);
    aux_case(12'hFFF, 4'h0);
  endtask

  task automatic test_limits();
    wr(PMR_CMD_AUX_OV_LIMIT, 16'hF800, 1'b0);
    rd(PMR_CMD_AUX_OV_LIMIT, 64'h0800);
    wr(PMR_CMD_AUX_UV_LIMIT, 16'hF100, 1'b0);
    rd(PMR_CMD_AUX_UV_LIMIT, 64'h0100);
    wr(PMR_CMD_ALERT1_CFG, 16'h0040, 1'b0);
    wr(PMR_CMD_ALERT2_CFG, 16'h0020, 1'b0);
    rd(PMR_CMD_ALERT1_CFG, 64'h0040);
  endtask

  task automatic test_aux();
    aux_case(12'h900, 4'hA);
    rd(PMR_CMD_AUX_READ, 64'h0900);
    aux_case(12'h050, 4'h5);
    aux_case(12'h800, 4'h0);
    aux_case(12'h100, 4'h0);
  endtask

  task automatic test_energy();
    repeat (3) send_power(16'h0010);
    send_power(16'hFFF0);
    rd(PMR_CMD_ENERGY_REC, {24'h000004, 16'h0000, 24'h000030});
    `check_eq("signed record", ({24'h000004, 16'h0000, 24'h000030}), rd_data_sgn)
    @(posedge clock);
    power_valid <= 1'b1;
    power_sample <= 16'h7FFF;
    repeat (512) @(posedge clock);
    power_valid <= 1'b0;
    rd(PMR_CMD_ENERGY_REC, {24'h000204, 16'h0000, 24'hFFFE30});
    `check_eq("signed record", ({24'h000204, 16'h0001, 24'h7FFE30}), rd_data_sgn)
    send_power(16'h01D0);
    rd(PMR_CMD_ENERGY_REC, {24'h000205, 16'h0001, 24'h000000});
    `check_eq("signed record", ({24'h000205, 16'h0002, 24'h000000}), rd_data_sgn)
  endtask

  task automatic test_trackers();
    rd(PMR_CMD_MIN_POWER, 64'hFFF0);
    wr(PMR_CMD_MIN_POWER, 16'h0005, 1'b1);
    wr(PMR_CMD_MIN_POWER, 16'h0000, 1'b0);
    rd(PMR_CMD_MIN_POWER, 64'h7FFF);
    send_current(16'h0100);
    send_current(16'hFF00);
    send_current(16'h0010);
    rd(PMR_CMD_MIN_CURRENT, 64'hFF00);
    wr(PMR_CMD_MIN_CURRENT, 16'h0001, 1'b1);
    rd(PMR_CMD_MIN_CURRENT, 64'hFF00);
    wr(PMR_CMD_MIN_CURRENT, 16'h0000, 1'b0);
    rd(PMR_CMD_MIN_CURRENT, 64'h07FF);
  endtask

  initial
  begin
    reset_n = 1'b0;
    power_valid = 1'b0;
    power_sample = 16'h0000;
    aux_valid = 1'b0;
    aux_sample = 12'h000;
    current_valid = 1'b0;
    current_sample = 16'h0000;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    test_reset();
    test_limits();
    test_aux();
    test_energy();
    test_trackers();
    complete_run();
  end
endmodule // pmr_readout_regs_bench
`default_nettype wire

// file: src/pmr_min_tracker.sv
`timescale 1ns/100ps
`default_nettype none

module pmr_min_tracker
  import pmr_pkg::*;
#(
  parameter logic [15:0] DEFAULT_VALUE = 16'h7FFF
)
(
  input wire logic clock, // system clock
  input wire logic reset_n, // synchronous reset
  input wire logic result_valid, // new averaged result
  input wire logic [15:0] result, // signed result
  input wire logic clear, // host wrote zero
  output logic [15:0] min_value // held minimum
);

  logic [15:0] min_reg;
  logic [15:0] min_next;
  logic [15:0] base;

  always_comb
  begin
    // a clear and a new result together: the result still counts
    base = clear ? DEFAULT_VALUE : min_reg;
    min_next = base;
    if (result_valid && ($signed(result) < $signed(base)))
    begin
      min_next = result;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      min_reg <= DEFAULT_VALUE;
    end
    else
    begin
      min_reg <= min_next;
    end
  end

  assign min_value = min_reg;

endmodule // pmr_min_tracker

`default_nettype wire

// file: src/pmr_pkg.sv
package pmr_pkg;

  // command codes of the readout registers
  localparam logic [7:0] PMR_CMD_ENERGY_REC = 8'hDC;
  localparam logic [7:0] PMR_CMD_AUX_READ = 8'hDD;
  localparam logic [7:0] PMR_CMD_AUX_OV_LIMIT = 8'hDE;
  localparam logic [7:0] PMR_CMD_AUX_UV_LIMIT = 8'hDF;
  localparam logic [7:0] PMR_CMD_MIN_CURRENT = 8'hE3;
  localparam logic [7:0] PMR_CMD_MIN_POWER = 8'hE4;
  localparam logic [7:0] PMR_CMD_ALERT1_CFG = 8'hD6;
  localparam logic [7:0] PMR_CMD_ALERT2_CFG = 8'hD7;

  // energy record field positions
  localparam int PMR_COUNT_LSB = 40;
  localparam int PMR_WRAP_LSB = 24;
  localparam int PMR_ENERGY_LSB = 0;

  // alert configuration bit positions
  localparam int PMR_ALERT_OV_BIT = 6;
  localparam int PMR_ALERT_UV_BIT = 5;

  // values after reset
  localparam logic [23:0] PMR_COUNT_RESET = 24'h000000;
  localparam logic [15:0] PMR_WRAP_RESET = 16'h0000;
  localparam logic [23:0] PMR_ENERGY_RESET = 24'h000000;
  localparam logic [11:0] PMR_AUX_RESET = 12'h000;
  localparam logic [11:0] PMR_OV_LIMIT_RESET = 12'hFFF;
  localparam logic [11:0] PMR_UV_LIMIT_RESET = 12'h000;
  localparam logic [15:0] PMR_MIN_CURRENT_RESET = 16'h07FF;
  localparam logic [15:0] PMR_MIN_POWER_RESET = 16'h7FFF;
  localparam logic [15:0] PMR_ALERT_CFG_RESET = 16'h0000;

  // energy wrap points
  localparam logic [23:0] PMR_ENERGY_MAX_UNSIGNED = 24'hFFFFFF;
  localparam logic [23:0] PMR_ENERGY_MAX_SIGNED = 24'h7FFFFF;

endpackage : pmr_pkg

// file: src/pmr_readout_regs.sv
`timescale 1ns/100ps
`default_nettype none

module pmr_readout_regs
  import pmr_pkg::*;
#(
  parameter bit SIGNED_ENERGY = 1'b0
)
(
  input wire logic clock, // 40 MHz system clock
  input wire logic reset_n, // synchronous, active low
  input wire logic cmd_valid, // command strobe from bus engine
  input wire logic cmd_write, // 1 write, 0 read
  input wire logic [7:0] cmd_code, // command code
  input wire logic [15:0] cmd_wdata, // write data word
  output logic [63:0] rd_data, // read answer, all 64 bits for the energy record, low bits otherwise
  output logic rd_valid, // read answer strobe
  output logic cmd_error, // unknown code or refused write
  input wire logic power_valid, // new power sample
  input wire logic [15:0] power_sample, // signed power sample
  input wire logic aux_valid, // new averaged aux reading
  input wire logic [11:0] aux_sample, // averaged aux reading
  input wire logic current_valid, // new averaged current
  input wire logic [15:0] current_sample, // signed current
  output logic aux_ov_warn, // aux overvoltage warning
  output logic aux_uv_warn, // aux undervoltage warning
  output logic alert1, // alert output 1, active high
  output logic alert2 // alert output 2, active high
);

  logic [23:0] count_reg;
  logic [23:0] count_next;
  logic [15:0] wrap_reg;
  logic [15:0] wrap_next;
  logic [23:0] energy_reg;
  logic [23:0] energy_next;
  logic energy_wrap;
  logic [24:0] energy_sum;
  logic [11:0] aux_reg;
  logic [11:0] aux_next;
  logic [11:0] ov_limit_reg;
  logic [11:0] ov_limit_next;
  logic [11:0] uv_limit_reg;
  logic [11:0] uv_limit_next;
  logic [15:0] alert1_cfg_reg;
  logic [15:0] alert1_cfg_next;
  logic [15:0] alert2_cfg_reg;
  logic [15:0] alert2_cfg_next;
  logic ov_warn_reg;
  logic ov_warn_next;
  logic uv_warn_reg;
  logic uv_warn_next;
  logic alert1_reg;
  logic alert1_next;
  logic alert2_reg;
  logic alert2_next;
  logic [63:0] rd_data_reg;
  logic [63:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic cmd_error_reg;
  logic cmd_error_next;
  logic [63:0] record;
  logic [15:0] min_current;
  logic [15:0] min_power;
  logic clear_current;
  logic clear_power;
  logic do_write;
  logic do_read;

  assign do_write = cmd_valid && cmd_write;
  assign do_read = cmd_valid && !cmd_write;
  assign clear_current = do_write && (cmd_code == PMR_CMD_MIN_CURRENT)
    && (cmd_wdata == 16'h0000);
  assign clear_power = do_write && (cmd_code == PMR_CMD_MIN_POWER)
    && (cmd_wdata == 16'h0000);

  // energy record: forward samples only add when positive
  always_comb
  begin
    count_next = count_reg;
    wrap_next = wrap_reg;
    energy_next = energy_reg;
    energy_sum = {1'b0, energy_reg};
    energy_wrap = 1'b0;
    if (power_valid)
    begin
      count_next = count_reg + 24'h000001;
      if (!power_sample[15])
      begin
        energy_sum = {1'b0, energy_reg} + {9'h000, power_sample};
        if (SIGNED_ENERGY)
        begin
          energy_wrap = energy_sum[23];
          energy_next = {1'b0, energy_sum[22:0]};
        end
        else
        begin
          energy_wrap = energy_sum[24];
          energy_next = energy_sum[23:0];
        end
      end
    end
    if (energy_wrap)
    begin
      wrap_next = wrap_reg + 16'h0001;
    end
  end

  assign record = {count_reg, wrap_reg, energy_reg};

  // aux reading, limits, enables and warnings
  always_comb
  begin
    aux_next = aux_valid ? aux_sample : aux_reg;
    ov_limit_next = ov_limit_reg;
    uv_limit_next = uv_limit_reg;
    alert1_cfg_next = alert1_cfg_reg;
    alert2_cfg_next = alert2_cfg_reg;
    if (do_write)
    begin
      unique case (cmd_code)
        PMR_CMD_AUX_OV_LIMIT: ov_limit_next = cmd_wdata[11:0];
        PMR_CMD_AUX_UV_LIMIT: uv_limit_next = cmd_wdata[11:0];
        PMR_CMD_ALERT1_CFG: alert1_cfg_next = cmd_wdata;
        PMR_CMD_ALERT2_CFG: alert2_cfg_next = cmd_wdata;
        default: ;
      endcase
    end
    ov_warn_next = (ov_limit_reg != PMR_OV_LIMIT_RESET)
      && (aux_reg > ov_limit_reg);
    uv_warn_next = (uv_limit_reg != PMR_UV_LIMIT_RESET)
      && (aux_reg < uv_limit_reg);
    alert1_next = (ov_warn_reg && alert1_cfg_reg[PMR_ALERT_OV_BIT])
      || (uv_warn_reg && alert1_cfg_reg[PMR_ALERT_UV_BIT]);
    alert2_next = (ov_warn_reg && alert2_cfg_reg[PMR_ALERT_OV_BIT])
      || (uv_warn_reg && alert2_cfg_reg[PMR_ALERT_UV_BIT]);
  end

  // command answers
  always_comb
  begin
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    cmd_error_next = 1'b0;
    if (do_read)
    begin
      rd_valid_next = 1'b1;
      unique case (cmd_code)
        PMR_CMD_ENERGY_REC: rd_data_next = record;
        PMR_CMD_AUX_READ: rd_data_next = {52'h0, aux_reg};
        PMR_CMD_AUX_OV_LIMIT: rd_data_next = {52'h0, ov_limit_reg};
        PMR_CMD_AUX_UV_LIMIT: rd_data_next = {52'h0, uv_limit_reg};
        PMR_CMD_MIN_CURRENT: rd_data_next = {48'h0, min_current};
        PMR_CMD_MIN_POWER: rd_data_next = {48'h0, min_power};
        PMR_CMD_ALERT1_CFG: rd_data_next = {48'h0, alert1_cfg_reg};
        PMR_CMD_ALERT2_CFG: rd_data_next = {48'h0, alert2_cfg_reg};
        default:
        begin
          rd_data_next = 64'h0;
          cmd_error_next = 1'b1;
        end
      endcase
    end
    else if (do_write)
    begin
      unique case (cmd_code)
        PMR_CMD_AUX_OV_LIMIT, PMR_CMD_AUX_UV_LIMIT,
        PMR_CMD_ALERT1_CFG, PMR_CMD_ALERT2_CFG: cmd_error_next = 1'b0;
        PMR_CMD_MIN_CURRENT, PMR_CMD_MIN_POWER:
          cmd_error_next = (cmd_wdata != 16'h0000);
        default: cmd_error_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      count_reg <= PMR_COUNT_RESET;
      wrap_reg <= PMR_WRAP_RESET;
      energy_reg <= PMR_ENERGY_RESET;
      aux_reg <= PMR_AUX_RESET;
      ov_limit_reg <= PMR_OV_LIMIT_RESET;
      uv_limit_reg <= PMR_UV_LIMIT_RESET;
      alert1_cfg_reg <= PMR_ALERT_CFG_RESET;
      alert2_cfg_reg <= PMR_ALERT_CFG_RESET;
      ov_warn_reg <= 1'b0;
      uv_warn_reg <= 1'b0;
      alert1_reg <= 1'b0;
      alert2_reg <= 1'b0;
      rd_data_reg <= 64'h0;
      rd_valid_reg <= 1'b0;
      cmd_error_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      wrap_reg <= wrap_next;
      energy_reg <= energy_next;
      aux_reg <= aux_next;
      ov_limit_reg <= ov_limit_next;
      uv_limit_reg <= uv_limit_next;
      alert1_cfg_reg <= alert1_cfg_next;
      alert2_cfg_reg <= alert2_cfg_next;
      ov_warn_reg <= ov_warn_next;
      uv_warn_reg <= uv_warn_next;
      alert1_reg <= alert1_next;
      alert2_reg <= alert2_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      cmd_error_reg <= cmd_error_next;
    end
  end

  pmr_min_tracker #(
    .DEFAULT_VALUE(PMR_MIN_CURRENT_RESET)
  ) u_min_current (
    .clock(clock),
    .reset_n(reset_n),
    .result_valid(current_valid),
    .result(current_sample),
    .clear(clear_current),
    .min_value(min_current)
  );

  pmr_min_tracker #(
    .DEFAULT_VALUE(PMR_MIN_POWER_RESET)
  ) u_min_power (
    .clock(clock),
    .reset_n(reset_n),
    .result_valid(power_valid),
    .result(power_sample),
    .clear(clear_power),
    .min_value(min_power)
  );

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign cmd_error = cmd_error_reg;
  assign aux_ov_warn = ov_warn_reg;
  assign aux_uv_warn = uv_warn_reg;
  assign alert1 = alert1_reg;
  assign alert2 = alert2_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_sample_count_step: assert property (
    power_valid |=> count_reg == $past(count_reg) + 24'h000001)
    else $error("sample count did not step");

  a_wrap_count_step: assert property (
    energy_wrap |=> wrap_reg == $past(wrap_reg) + 16'h0001)
    else $error("wrap count missed a rollover");

  a_wrap_count_hold: assert property (
    !energy_wrap |=> $stable(wrap_reg))
    else $error("wrap count moved without rollover");

  a_energy_signed_range: assert property (
    SIGNED_ENERGY |-> !energy_reg[23])
    else $error("signed energy left positive range");

  a_record_read_layout: assert property (
    do_read && cmd_code == PMR_CMD_ENERGY_REC
    |=> rd_valid && rd_data == {$past(count_reg), $past(wrap_reg), $past(energy_reg)})
    else $error("energy record read layout wrong");

  a_aux_read_upper: assert property (
    do_read && cmd_code == PMR_CMD_AUX_READ
    |=> rd_data[63:12] == 52'h0 && rd_data[11:0] == $past(aux_reg))
    else $error("aux reading upper bits not zero");

  a_limit_read_upper: assert property (
    do_read && (cmd_code == PMR_CMD_AUX_OV_LIMIT || cmd_code == PMR_CMD_AUX_UV_LIMIT)
    |=> rd_data[15:12] == 4'h0)
    else $error("limit reserved bits not zero");

  a_ov_disabled: assert property (
    ov_limit_reg == PMR_OV_LIMIT_RESET |=> !aux_ov_warn)
    else $error("overvoltage warning while disabled");

  a_uv_disabled: assert property (
    uv_limit_reg == PMR_UV_LIMIT_RESET |=> !aux_uv_warn)
    else $error("undervoltage warning while disabled");

  a_ov_flag_raise: assert property (
    ov_limit_reg != PMR_OV_LIMIT_RESET && aux_reg > ov_limit_reg |=> aux_ov_warn)
    else $error("overvoltage warning not raised");

  a_alert_gate: assert property (
    !alert1_cfg_reg[PMR_ALERT_OV_BIT] && !alert1_cfg_reg[PMR_ALERT_UV_BIT]
    && $stable(alert1_cfg_reg) |=> !alert1)
    else $error("alert1 raised while disabled");

  a_min_current_clear: assert property (
    clear_current && !current_valid |=> min_current == PMR_MIN_CURRENT_RESET)
    else $error("current tracker not restored");

  a_min_power_keep: assert property (
    power_valid && !clear_power && $signed(power_sample) >= $signed(min_power)
    |=> $stable(min_power))
    else $error("power tracker took a larger result");

  c_energy_wrap: cover property (energy_wrap);
  c_record_read: cover property (do_read && cmd_code == PMR_CMD_ENERGY_REC ##1 rd_valid);
  c_alert1_ov: cover property (alert1 && aux_ov_warn);
  c_power_clear: cover property (clear_power ##1 power_valid);

endmodule // pmr_readout_regs

`default_nettype wire
